// ==== verilog/octal_serial_driver_control.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Each of eight channels owns one latch bit; reset clears all, outputs off.
// - Eight-bit control word shifted in and held to drive output stages.
// - Eight diagnostic bits shift out per transfer, one per sensed output.
// - Device is selected only while chip select is low.
// - Serial output is released whenever chip select is high.
// - Chip select fall loads shift register with sensed output levels.
// - Chip select rise loads the inverted shift register into the output latch.
// - After each shift clock rise, next shift register bit appears on output.
// - Each shift clock fall captures serial input into shift register.
// - Shifting out and in happen together, allowing daisy chaining.
// - A fault clears only its own channel's latch bit.
// - Commanded on but sensed high clears that channel's latch bit.
// - Open channel commanded off reports low via sensed level.
// - Output stage drive is active low when latch commands the channel on.
// - Serial bit one means off, zero means on.
// - Channel seven goes first, channel zero last.
// - Fault clearing suppressed for a delay after chip select rises.
// - Shift clock ignored while chip select is high.
module octal_serial_driver_control (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       sdi,
	input  wire logic [7:0] sense_high,
	output logic            sdo,
	output logic            sdo_oe,
	output logic [7:0]      drive_n,
	output logic [7:0]      latch_q
);
	sync_bus cs_bus ();
	sync_bus ck_bus ();
	sync_bus di_bus ();

	logic [7:0] sense_s1_ff;
	logic [7:0] sense_ff;
	logic       cs_d_ff;
	logic       ck_d_ff;
	logic [7:0] shift_ff;
	logic [14:0] guard_ff;
	logic       cs_s;
	logic       ck_s;
	logic       di_s;
	logic       cs_fall;
	logic       cs_rise;
	logic       ck_rise;
	logic       ck_fall;
	logic       selected;
	logic       guard_busy;

	assign cs_bus.raw = cs_n;
	assign ck_bus.raw = sclk;
	assign di_bus.raw = sdi;
	assign cs_s = cs_bus.level;
	assign ck_s = ck_bus.level;
	assign di_s = di_bus.level;

	// Chip select idles high; a low reset value would fake a select
	// right after reset and latch a stale byte into the outputs
	sync2 #(
		.RESET_LEVEL (1'b1)
	) u_cs (
		.clk    (clk),
		.resetn (resetn),
		.din    (cs_bus.raw),
		.dout   (cs_bus.level)
	);
	sync2 u_ck (
		.clk    (clk),
		.resetn (resetn),
		.din    (ck_bus.raw),
		.dout   (ck_bus.level)
	);
	sync2 u_di (
		.clk    (clk),
		.resetn (resetn),
		.din    (di_bus.raw),
		.dout   (di_bus.level)
	);

	// Sense inputs are analog comparator levels, so they are synchronised too
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sense_s1_ff <= 8'h00;
			sense_ff    <= 8'h00;
		end else begin
			sense_s1_ff <= sense_high;
			sense_ff    <= sense_s1_ff;
		end
	end

	// Reset value of one keeps cs looking idle after reset
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cs_d_ff <= 1'b1;
			ck_d_ff <= 1'b0;
		end else begin
			cs_d_ff <= cs_s;
			ck_d_ff <= ck_s;
		end
	end

	assign selected = !cs_s && !cs_d_ff;
	assign cs_fall  = cs_d_ff && !cs_s;
	assign cs_rise  = !cs_d_ff && cs_s;
	assign ck_rise  = selected && ck_s && !ck_d_ff;
	assign ck_fall  = selected && !ck_s && ck_d_ff;

	// Shift register: parallel jam on select, serial in on clock fall
	always_ff @(posedge clk) begin
		if (!resetn) begin
			shift_ff <= drv_pkg::SHIFT_RESET;
		end else if (cs_fall) begin
			shift_ff <= sense_ff;
		end else if (ck_fall) begin
			// Only the last eight bits survive; older ones leave on sdo
			shift_ff <= {shift_ff[6:0], di_s};
		end
	end

	// Output shows MSB after each rise; shifting happens on fall, so the
	// bit shown after rise is the one about to leave
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sdo <= 1'b0;
		end else if (cs_fall) begin
			sdo <= sense_ff[drv_pkg::MSB];
		end else if (ck_rise) begin
			sdo <= shift_ff[drv_pkg::MSB];
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sdo_oe <= 1'b0;
		end else begin
			sdo_oe <= !cs_s;
		end
	end

	// Guard timer inhibits fault clearing while loads charge up
	always_ff @(posedge clk) begin
		if (!resetn) begin
			guard_ff <= 15'h0000;
		end else if (cs_rise) begin
			guard_ff <= drv_pkg::GUARD_CYCLES;
		end else if (guard_ff != 15'h0000) begin
			guard_ff <= guard_ff - 15'h0001;
		end
	end

	assign guard_busy = (guard_ff != 15'h0000);

	// Latch bit one means channel on; serial one means off
	always_ff @(posedge clk) begin
		if (!resetn) begin
			latch_q <= drv_pkg::LATCH_RESET;
		end else if (cs_rise) begin
			latch_q <= ~shift_ff;
		end else if (!guard_busy) begin
			latch_q <= latch_q & ~sense_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			drive_n <= 8'hFF;
		end else begin
			drive_n <= ~latch_q;
		end
	end

	// Counts shift clock falls in the current transfer for the checks.
	// It saturates, so a long daisy chain never wraps back into range.
	logic [4:0] clk_cnt_ff;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			clk_cnt_ff <= 5'h00;
		end else if (cs_fall) begin
			clk_cnt_ff <= 5'h00;
		end else if (ck_fall && clk_cnt_ff != 5'h1F) begin
			clk_cnt_ff <= clk_cnt_ff + 5'h01;
		end
	end

	sdo_oe_tracks_cs_a: assert property (
		@(posedge clk) disable iff (!resetn)
		1 |=> sdo_oe == !$past(cs_s))
		else $error("output enable does not follow select");

	latch_on_rise_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_rise |=> latch_q == ~$past(shift_ff))
		else $error("latch not loaded at end of transfer");

	jam_on_fall_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_fall |=> shift_ff == $past(sense_ff))
		else $error("shift register not loaded with sense levels");

	shift_in_a: assert property (
		@(posedge clk) disable iff (!resetn)
		ck_fall && !cs_fall |=> shift_ff[0] == $past(di_s))
		else $error("serial input not captured");

	shift_out_a: assert property (
		@(posedge clk) disable iff (!resetn)
		ck_rise && !cs_fall |=> sdo == $past(shift_ff[7]))
		else $error("serial output not updated");

	guard_holds_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_rise |=> ##1 guard_busy [*8])
		else $error("guard timer not running");

	fault_clear_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!cs_rise && !guard_busy && latch_q[0] && sense_ff[0]
		|=> !latch_q[0])
		else $error("faulted channel not switched off");

	idle_no_shift_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_s && cs_d_ff |=> $stable(shift_ff))
		else $error("shift register moved while deselected");

	drive_follow_a: assert property (
		@(posedge clk) disable iff (!resetn)
		1 |=> drive_n == ~$past(latch_q))
		else $error("drive does not follow latch");

	reset_clear_a: assert property (
		@(posedge clk)
		!resetn |=> latch_q == 8'h00 && !sdo_oe)
		else $error("reset did not clear latch");

	sdo_hold_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!cs_fall && !ck_rise |=> $stable(sdo))
		else $error("serial output moved without a clock rise");

	first_bit_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_fall |=> sdo == $past(sense_ff[7]))
		else $error("first serial bit is not channel seven");

	shift_chain_a: assert property (
		@(posedge clk) disable iff (!resetn)
		ck_fall && !cs_fall |=> shift_ff[7:1] == $past(shift_ff[6:0]))
		else $error("shift register did not move up");

	latch_guarded_a: assert property (
		@(posedge clk) disable iff (!resetn)
		guard_busy && !cs_rise |=> $stable(latch_q))
		else $error("latch changed while guard running");

	only_clears_a: assert property (
		@(posedge clk) disable iff (!resetn)
		!cs_rise |=> (latch_q & ~$past(latch_q)) == 8'h00)
		else $error("latch bit set outside a transfer");

	guard_load_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_rise |=> guard_ff == drv_pkg::GUARD_CYCLES)
		else $error("guard timer not loaded");

	idle_released_a: assert property (
		@(posedge clk) disable iff (!resetn)
		cs_s && cs_d_ff |=> !sdo_oe)
		else $error("serial output driven while deselected");

	transfer_c: cover property (@(posedge clk) disable iff (!resetn) cs_rise);

	fault_c: cover property (@(posedge clk) disable iff (!resetn)
		!guard_busy && |(latch_q & sense_ff));

	shift_c: cover property (@(posedge clk) disable iff (!resetn) ck_fall);

	// A plain byte and a chained transfer longer than one byte
	byte_xfer_c: cover property (@(posedge clk) disable iff (!resetn)
		cs_rise && clk_cnt_ff == 5'h08);

	chain_xfer_c: cover property (@(posedge clk) disable iff (!resetn)
		cs_rise && clk_cnt_ff > 5'h08);
endmodule

// ==== verilog/drv_pkg.sv ====
package drv_pkg;
	localparam int          CHANNELS       = 8;
	localparam int          CNT_W          = 15;
	localparam int          CLK_PERIOD_NS  = 10;
	localparam int          GUARD_DELAY_US = 160;
	localparam logic [14:0] GUARD_CYCLES   =
		15'(GUARD_DELAY_US * 1000 / CLK_PERIOD_NS);
	localparam logic [7:0]  LATCH_RESET    = 8'h00;
	localparam logic [7:0]  SHIFT_RESET    = 8'h00;
	localparam int          MSB            = 7;
endpackage

// ==== verilog/sync_bus.sv ====
`timescale 1ns/10ps
interface sync_bus;
	logic level;
	logic raw;
	modport src (output raw);
	modport dst (input level);
	modport sync (input raw, output level);
endinterface

// ==== verilog/sync2.sv ====
`timescale 1ns/10ps
// Reset level is set per instance so that a synchronised pin reads as its
// idle level straight after reset and no false edge is seen on release
module sync2 #(
	parameter logic RESET_LEVEL = 1'b0
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic din,
	output logic      dout
);
	logic meta_ff;

	// First stage is read only by the second stage
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta_ff <= RESET_LEVEL;
			dout    <= RESET_LEVEL;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule

// ==== test/spi_ctrl_model.sv ====
`timescale 1ns/10ps
module spi_ctrl_model (
	input  wire logic clk,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      sdi
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// Four clocks per phase gives the 80 ns link period
	task automatic xfer(input logic [15:0] tx, input int n,
		output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clk) cs_n <= 1'b0;
		repeat (8) @(negedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			sdi <= tx[i];
			sclk <= 1'b1;
			repeat (4) @(negedge clk);
			sclk <= 1'b0;
			repeat (4) @(negedge clk);
			// Sampled late, where the bit still stands; a released line reads inverted
			rx = {rx[14:0], sdo_oe ? sdo : ~rx[0]};
		end
		cs_n <= 1'b1;
		repeat (8) @(negedge clk);
	endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/10ps
module tb;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  sense_high = 8'hFF;
	logic [7:0]  short_m = 8'h00;
	logic [7:0]  open_m = 8'h00;
	logic        cs_n, sclk, sdi, sdo, sdo_oe;
	logic [7:0]  drive_n, latch_q;
	logic [15:0] rx, tx, nt;
	int          error_cnt = 0, checks = 0, seed = 76;
	always #5 clk = ~clk;
	// Load: off pins pulled high, shorted pins stay high, open pins read low
	always @(negedge clk) sense_high <= (drive_n | short_m) & ~open_m;
	spi_ctrl_model i_spi_ctrl_model (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe),
		.cs_n(cs_n), .sclk(sclk), .sdi(sdi));
	octal_serial_driver_control i_octal_serial_driver_control (.clk(clk),
		.resetn(resetn), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.sense_high(sense_high), .sdo(sdo), .sdo_oe(sdo_oe),
		.drive_n(drive_n), .latch_q(latch_q));
	function automatic logic [15:0] exp_diag(input logic [7:0] drv);
		return {8'h00, (drv | short_m) & ~open_m};
	endfunction
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#1000000;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		repeat (5) @(negedge clk);
		resetn <= 1'b1;
		check({drive_n, latch_q}, 16'hFF00);
		check({15'h0000, sdo_oe}, 16'h0000);
		$display("test reset done");
		tx = 16'h00FF;
		for (int k = 0; k < 6; k++) begin
			nt = (k == 0) ? 16'h0000 : 16'($random(seed)) & 16'h00FF;
			i_spi_ctrl_model.xfer(nt, 8, rx);
			check(rx, exp_diag(tx[7:0]));
			check({drive_n, latch_q}, {nt[7:0], ~nt[7:0]});
			check({15'h0000, sdo_oe}, 16'h0000);
			tx = nt;
		end
		$display("test random done");
		short_m = 8'h10;
		i_spi_ctrl_model.xfer(16'h0000, 8, rx);
		check(rx, exp_diag(tx[7:0]));
		repeat (15900) @(negedge clk);
		check({8'h00, latch_q}, 16'h00FF);
		repeat (200) @(negedge clk);
		check({8'h00, latch_q}, 16'h00EF);
		$display("test fault done");
		short_m = 8'h00;
		open_m = 8'h01;
		i_spi_ctrl_model.xfer(16'h0001, 8, rx);
		check(rx, 16'h0010);
		i_spi_ctrl_model.xfer(16'h0001, 8, rx);
		check(rx, 16'h0000);
		$display("test open done");
		nt = 16'($random(seed));
		i_spi_ctrl_model.xfer(nt, 16, rx);
		check(rx, {exp_diag(8'h01), nt[15:8]});
		check({8'h00, latch_q}, {8'h00, ~nt[7:0]});
		$display("test chain done");
		report_and_stop;
	end
endmodule
